// [logic/led_ctrl_pkg.sv]
package led_ctrl_pkg;

  // ----------------------------------------------------------------
  // serial bus
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h53;
  localparam logic [3:0] BIT_CNT_LAST  = 4'h8;
  localparam logic [3:0] BIT_CNT_FIRST = 4'h1;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int REG_COUNT   = 9;
  localparam int IDX_MODE    = 0;
  localparam int IDX_IND     = 1;
  localparam int IDX_AUX     = 2;
  localparam int IDX_LOW     = 4;
  localparam int IDX_HIGH    = 5;
  localparam int IDX_TIMEOUT = 6;

  localparam logic [7:0] REG_OFFSET [REG_COUNT] = '{
    8'h10, 8'h12, 8'h20, 8'h80, 8'hA0, 8'hB0, 8'hC0, 8'hE0, 8'hF0};
  localparam logic [7:0] REG_RESET [REG_COUNT] = '{
    8'hF8, 8'hF8, 8'h80, 8'hF8, 8'hFA, 8'hFD, 8'hEF, 8'h6A, 8'hF0};
  // writable bits; the rest always read as their reset level
  localparam logic [7:0] REG_MASK [REG_COUNT] = '{
    8'h07, 8'h07, 8'h7F, 8'h07, 8'h07, 8'h0F, 8'h3F, 8'hFF, 8'hFF};

  localparam logic [7:0] FAULT_OFFSET = 8'hD0;
  localparam logic [7:0] FAULT_RESET  = 8'h00;
  localparam logic [7:0] FAULT_MASK   = 8'hBF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EDGE_BIT     = 2;
  localparam int AUX1_GPIO    = 0;
  localparam int AUX1_DIR     = 1;
  localparam int AUX1_DATA    = 2;
  localparam int AUX2_GPIO    = 3;
  localparam int AUX2_DIR     = 4;
  localparam int AUX2_DATA    = 5;
  localparam int AUX2_INT     = 6;
  localparam int FLAG_TIMEOUT = 0;
  localparam int FLAG_TSD     = 1;
  localparam int FLAG_LEDF    = 2;
  localparam int FLAG_TX1     = 3;
  localparam int FLAG_TX2     = 4;
  localparam int FLAG_THERM   = 5;
  localparam int FLAG_SUPPLY  = 7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int TIMEOUT_STEP_NS = 32_000_000;
  localparam int STEP_CNT_W      = 24;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHUTDOWN  = 2'h0,
    MODE_INDICATOR = 2'h1,
    MODE_TORCH     = 2'h2,
    MODE_FLASH     = 2'h3
  } op_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_REG       = 4'h2,
    ST_REG_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RACK      = 4'hC
  } bus_state_e;

  typedef struct packed {
    logic thermal_shutdown;
    logic led_fail;
    logic led_thermal_fault;
    logic supply_low;
  } fault_in_s;

  typedef struct packed {
    op_mode_e   mode;
    logic       flash_on;
    logic [2:0] indicator_code;
    logic [2:0] low_code;
    logic [3:0] high_code;
  } led_ctrl_s;

endpackage

// [logic/led_sync2.sv]
`timescale 1ns/1ns
module led_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // led_sync2

// [logic/led_driver_control_port.sv]
`timescale 1ns/1ns
module led_driver_control_port #(
  parameter int TIMEOUT_STEP_CYCLES =
    led_ctrl_pkg::TIMEOUT_STEP_NS / led_ctrl_pkg::CLK_PERIOD_NS
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  input  wire logic                   trigger_i,
  input  wire logic                   aux_pin_one_i,
  output logic                        aux_pin_one_o,
  output logic                        aux_pin_one_oe,
  input  wire logic                   aux_pin_two_i,
  output logic                        aux_pin_two_o,
  output logic                        aux_pin_two_oe,
  input  wire led_ctrl_pkg::fault_in_s fault_i,
  output led_ctrl_pkg::led_ctrl_s     ctrl_o
);
  import led_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [8:0] pin_raw;
  logic [8:0] pin_s;
  logic       scl_s, sda_s, trig_s, aux1_s, aux2_s;
  fault_in_s  fault_s;
  logic       scl_prev_q, sda_prev_q, trig_prev_q;
  logic       aux1_prev_q, aux2_prev_q;

  assign pin_raw = {fault_i, aux_pin_two_i, aux_pin_one_i, trigger_i,
                    sda_i, scl_i};

  led_sync2 #(.WIDTH(9)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d_i      (pin_raw),
    .q_o      (pin_s)
  );

  assign scl_s   = pin_s[0];
  assign sda_s   = pin_s[1];
  assign trig_s  = pin_s[2];
  assign aux1_s  = pin_s[3];
  assign aux2_s  = pin_s[4];
  assign fault_s = pin_s[8:5];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_prev_q  <= 1'b0;
      sda_prev_q  <= 1'b0;
      trig_prev_q <= 1'b0;
      aux1_prev_q <= 1'b0;
      aux2_prev_q <= 1'b0;
    end else begin
      scl_prev_q  <= scl_s;
      sda_prev_q  <= sda_s;
      trig_prev_q <= trig_s;
      aux1_prev_q <= aux1_s;
      aux2_prev_q <= aux2_s;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  bus_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, ptr_q;
  logic       rw_q, nack_q, sda_oe_q;
  logic       start_det, stop_det, scl_rise, scl_fall, byte_done;
  logic       addr_hit, load_rd, wr_stb, flag_clr, fault_hit;
  logic [7:0] rd_data;

  // the master alone makes these; the device only watches
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign byte_done = scl_fall & (bit_cnt_q == BIT_CNT_LAST);
  assign addr_hit  = rx_q[7:1] == DEV_ADDR;
  assign wr_stb    = byte_done & (state_q == ST_WDATA);
  assign load_rd   = scl_fall & (((state_q == ST_ADDR_ACK) & rw_q) |
                     ((state_q == ST_RACK) & ~nack_q));
  assign fault_hit = ptr_q == FAULT_OFFSET;
  assign flag_clr  = load_rd & fault_hit;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q      <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      // sample on rising scl, drive on falling scl
      if (scl_rise) begin
        rx_q <= {rx_q[6:0], sda_s};
        if (state_q == ST_RACK) begin
          nack_q <= sda_s;
        end
        if (state_q == ST_ADDR || state_q == ST_REG ||
            state_q == ST_WDATA) begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
      if (load_rd) begin
        tx_q      <= {rd_data[6:0], 1'b1};
        sda_oe_q  <= ~rd_data[7];
        bit_cnt_q <= BIT_CNT_FIRST;
        state_q   <= ST_RDATA;
      end else if (scl_fall) begin
        unique case (state_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR: begin
            if (byte_done) begin
              rw_q     <= rx_q[0];
              sda_oe_q <= addr_hit;
              state_q  <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
            end
          end
          ST_ADDR_ACK: begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q   <= ST_REG;
          end
          ST_REG: begin
            if (byte_done) begin
              ptr_q    <= rx_q;
              sda_oe_q <= 1'b1;
              state_q  <= ST_REG_ACK;
            end
          end
          ST_REG_ACK: begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q   <= ST_WDATA;
          end
          ST_WDATA: begin
            if (byte_done) begin
              sda_oe_q <= 1'b1;
              state_q  <= ST_WDATA_ACK;
            end
          end
          ST_WDATA_ACK: begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q   <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_q == BIT_CNT_LAST) begin
              sda_oe_q <= 1'b0;
              state_q  <= ST_RACK;
            end else begin
              sda_oe_q  <= ~tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b1};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          ST_RACK: begin
            sda_oe_q <= 1'b0;
            state_q  <= ST_IDLE;
          end
          default: begin
            sda_oe_q <= 1'b0;
            state_q  <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0]     regs_q [REG_COUNT];
  logic [7:0]     flags_q, flags_set, clr_vec;
  logic [REG_COUNT-1:0] ptr_hit;
  logic [7:0]     aux_cfg, aux_rd;
  logic           flash_q, flash_start, flash_end, timeout_hit;
  logic           edge_sel, step_tick;
  op_mode_e       mode_w;

  for (genvar i = 0; i < REG_COUNT; i++) begin : g_hit
    assign ptr_hit[i] = ptr_q == REG_OFFSET[i];
  end

  assign aux_cfg = regs_q[IDX_AUX];
  // an input-mode gpio reads back the pin, not the stored bit
  assign aux_rd  = {aux_cfg[7:6],
    (aux_cfg[AUX2_GPIO] & ~aux_cfg[AUX2_DIR]) ? aux2_s
                                              : aux_cfg[AUX2_DATA],
    aux_cfg[4:3],
    (aux_cfg[AUX1_GPIO] & ~aux_cfg[AUX1_DIR]) ? aux1_s
                                              : aux_cfg[AUX1_DATA],
    aux_cfg[1:0]};

  always_comb begin
    rd_data = fault_hit ? flags_q : 8'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (ptr_hit[i]) begin
        rd_data = (i == IDX_AUX) ? aux_rd : regs_q[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET[i];
      end
    end else begin
      for (int i = 0; i < REG_COUNT; i++) begin
        if (wr_stb && ptr_hit[i]) begin
          regs_q[i] <= (rx_q & REG_MASK[i]) |
                       (REG_RESET[i] & ~REG_MASK[i]);
        end
      end
      if (flash_end) begin
        regs_q[IDX_MODE][1:0] <= MODE_SHUTDOWN;
      end
    end
  end

  // hardware set wins over a read-clear in the same cycle
  assign flags_set = {fault_s.supply_low, 1'b0,
    fault_s.led_thermal_fault,
    ~aux_cfg[AUX2_GPIO] & aux2_s & ~aux2_prev_q,
    ~aux_cfg[AUX1_GPIO] & aux1_s & ~aux1_prev_q,
    fault_s.led_fail, fault_s.thermal_shutdown, timeout_hit};
  assign clr_vec = {8{flag_clr}} | ({7'h00, flash_start} << FLAG_TIMEOUT);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_q <= FAULT_RESET;
    end else begin
      flags_q <= ((flags_q & ~clr_vec) | flags_set) & FAULT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // flash pulse and timeout
  // ----------------------------------------------------------------
  logic [STEP_CNT_W-1:0] cyc_q;
  logic [4:0]            step_q;

  assign mode_w      = op_mode_e'(regs_q[IDX_MODE][1:0]);
  assign edge_sel    = regs_q[IDX_MODE][EDGE_BIT];
  assign step_tick   = cyc_q == STEP_CNT_W'(TIMEOUT_STEP_CYCLES - 1);
  assign timeout_hit = flash_q & step_tick &
                       (step_q == regs_q[IDX_TIMEOUT][4:0]);
  assign flash_start = ~flash_q & (mode_w == MODE_FLASH) &
    (edge_sel ? (trig_s & ~trig_prev_q) : trig_s);
  // edge mode ignores the trigger level once started
  assign flash_end   = flash_q & (timeout_hit |
                       (~edge_sel & ~trig_s));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_q <= 1'b0;
      cyc_q   <= '0;
      step_q  <= 5'h00;
    end else begin
      if (flash_start) begin
        flash_q <= 1'b1;
      end else if (flash_end || mode_w != MODE_FLASH) begin
        flash_q <= 1'b0;
      end
      if (!flash_q || step_tick) begin
        cyc_q <= '0;
      end else begin
        cyc_q <= cyc_q + 1'b1;
      end
      if (!flash_q) begin
        step_q <= 5'h00;
      end else if (step_tick) begin
        step_q <= step_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic int_mode;
  assign int_mode = aux_cfg[AUX2_INT] & aux_cfg[AUX2_GPIO] &
                    aux_cfg[AUX2_DIR];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aux_pin_one_o  <= 1'b0;
      aux_pin_one_oe <= 1'b0;
      aux_pin_two_o  <= 1'b0;
      aux_pin_two_oe <= 1'b0;
      ctrl_o         <= '0;
    end else begin
      aux_pin_one_oe <= aux_cfg[AUX1_GPIO] & aux_cfg[AUX1_DIR];
      aux_pin_one_o  <= aux_cfg[AUX1_DATA];
      aux_pin_two_oe <= int_mode ?
        (flags_q[FLAG_THERM] | flags_q[FLAG_SUPPLY]) :
        (aux_cfg[AUX2_GPIO] & aux_cfg[AUX2_DIR]);
      aux_pin_two_o  <= ~int_mode & aux_cfg[AUX2_DATA];
      ctrl_o.mode           <= mode_w;
      ctrl_o.flash_on       <= flash_q;
      ctrl_o.indicator_code <= regs_q[IDX_IND][2:0];
      ctrl_o.low_code       <= regs_q[IDX_LOW][2:0];
      ctrl_o.high_code      <= regs_q[IDX_HIGH][3:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_start_addr: assert property (
    start_det |=> state_q == ST_ADDR && bit_cnt_q == 4'h0)
    else $error("start did not restart address reception");
  chk_stop_idle: assert property (
    stop_det && !start_det |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("stop did not free the bus");
  chk_byte_len: assert property (
    bit_cnt_q <= BIT_CNT_LAST)
    else $error("bit count ran past a byte");
  chk_addr_nomatch: assert property (
    state_q == ST_ADDR && byte_done && !start_det && !stop_det &&
    !addr_hit |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("foreign address acknowledged");
  chk_ack_low: assert property (
    (state_q == ST_ADDR_ACK || state_q == ST_REG_ACK ||
     state_q == ST_WDATA_ACK) |-> sda_oe_q)
    else $error("ack slot not driven low");
  chk_write_ind: assert property (
    wr_stb && !start_det && !stop_det && ptr_q == REG_OFFSET[IDX_IND]
    |=> regs_q[IDX_IND] == (($past(rx_q) & REG_MASK[IDX_IND]) |
        (REG_RESET[IDX_IND] & ~REG_MASK[IDX_IND])))
    else $error("write data not stored");
  chk_flash_clear: assert property (
    flash_end |=> regs_q[IDX_MODE][1:0] == 2'h0 ##1 !flash_q)
    else $error("flash end did not clear mode");
  chk_level_off: assert property (
    flash_q && !edge_sel && !trig_s |=> !flash_q)
    else $error("level flash outlived trigger");
  chk_edge_hold: assert property (
    flash_q && edge_sel && !timeout_hit && mode_w == MODE_FLASH
    |=> flash_q)
    else $error("edge flash ended before timeout");
  chk_flag_clear: assert property (
    flag_clr && flags_set == 8'h00 |=> flags_q == 8'h00)
    else $error("fault read did not clear flags");
  chk_int_pin: assert property (
    int_mode && (flags_q[FLAG_THERM] || flags_q[FLAG_SUPPLY]) &&
    $stable(aux_cfg) |=> aux_pin_two_oe && !aux_pin_two_o)
    else $error("interrupt pin not pulled low");
endmodule // led_driver_control_port

// [tb/bus_master.sv]
`timescale 1ns/1ns
module bus_master (
  input  wire logic       core_clk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_drv,
  output logic [7:0]      rd_byte,
  output logic            rd_valid
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_byte = 8'h00;
    rd_valid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // bit and frame level
  // ----------------------------------------------------------------
  // data moves only mid-low, never in the cycle scl falls
  task automatic bit_slot(input logic b, output logic s);
    tick(4);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    s = sda_line;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic start();
    tick(4);
    sda_drv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_drv = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_drv = 1'b1;
    tick(8);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(last, s);
    rd_byte = d;
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // register transfers
  // ----------------------------------------------------------------
  task automatic write_reg(input logic [7:0] a, d, output logic [2:0] ak);
    start();
    send_byte(8'hA6, ak[2]);
    send_byte(a, ak[1]);
    send_byte(d, ak[0]);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [2:0] ak);
    logic [7:0] d;
    start();
    send_byte(8'hA6, ak[2]);
    send_byte(a, ak[1]);
    start();
    send_byte(8'hA7, ak[0]);
    recv_byte(1'b1, d);
    stop();
  endtask
endmodule // bus_master

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
  import led_ctrl_pkg::*;
  localparam logic [7:0] OFS [10] = '{8'h10, 8'h12, 8'h20, 8'h80, 8'hA0,
    8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0};
  localparam logic [7:0] RSV [10] = '{8'hF8, 8'hF8, 8'h80, 8'hF8, 8'hFA,
    8'hFD, 8'hEF, 8'h00, 8'h6A, 8'hF0};
  logic       core_clk, rst, trigger_i, ext1, ext2, scl, sda_drv;
  logic       sda_o, sda_oe, rd_valid, a1, a2;
  logic       aux_pin_one_o, aux_pin_one_oe, aux_pin_two_o, aux_pin_two_oe;
  logic [7:0] rd_byte, v, rb;
  logic [2:0] ak;
  fault_in_s  fault_i;
  led_ctrl_s  ctrl_o;
  logic [7:0] exp_q [$];
  int         err_total, total_checks, n;
  // open drain: the device pulls down with the value it presents
  wire sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
  wire aux1_w   = aux_pin_one_oe ? aux_pin_one_o : ext1;
  wire aux2_w   = aux_pin_two_oe ? aux_pin_two_o : ext2;

  led_driver_control_port #(.TIMEOUT_STEP_CYCLES(16)) dut (
    .core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .trigger_i(trigger_i),
    .aux_pin_one_i(aux1_w), .aux_pin_one_o(aux_pin_one_o),
    .aux_pin_one_oe(aux_pin_one_oe), .aux_pin_two_i(aux2_w),
    .aux_pin_two_o(aux_pin_two_o), .aux_pin_two_oe(aux_pin_two_oe),
    .fault_i(fault_i), .ctrl_o(ctrl_o));
  bus_master m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv), .rd_byte(rd_byte), .rd_valid(rd_valid));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk("read data", rd_byte, exp_q.pop_front());
      end else begin
        chk("unexpected read", 8'h00, 8'hFF);
      end
    end
  end
  task automatic wr(input logic [7:0] a, d);
    m.write_reg(a, d, ak);
    chk("write ack", {5'h0, ak}, 8'h07);
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    m.read_reg(a, ak);
    chk("read ack", {5'h0, ak}, 8'h07);
  endtask
  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_flash(input logic fv, input int lim);
    n = 0;
    while (ctrl_o.flash_on !== fv && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk("flash_on", {7'h0, ctrl_o.flash_on}, {7'h0, fv});
    if (ctrl_o.flash_on !== fv) conclude();
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    trigger_i = 1'b0;
    ext1 = 1'b0;
    ext2 = 1'b0;
    fault_i = '0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(25));
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("low code", {5'h0, ctrl_o.low_code}, 8'h02);
    chk("high code", {4'h0, ctrl_o.high_code}, 8'h0D);
    for (int i = 0; i < 10; i++) rd(OFS[i], RSV[i]);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'h00);
    rd(8'h55, 8'h00);
    // foreign address must stay unanswered
    m.start();
    m.send_byte(8'hA4, a1);
    m.stop();
    chk("foreign ack", {7'h0, a1}, 8'h00);
    // restart in mid-write aborts the first register selection
    m.start();
    m.send_byte(8'hA6, a1);
    m.send_byte(8'h80, a2);
    m.start();
    m.send_byte(8'hA6, a1);
    m.send_byte(8'h12, a2);
    m.send_byte(8'h03, a2);
    m.stop();
    rd(8'h80, 8'hF8);
    rd(8'h12, 8'hFB);
    for (int i = 0; i < REG_COUNT; i++) begin
      if (i != IDX_AUX) begin
        v = 8'($urandom);
        wr(REG_OFFSET[i], v);
        rd(REG_OFFSET[i], (RSV[i] & ~REG_MASK[i]) | (v & REG_MASK[i]));
      end
    end
    v = 8'($urandom);
    wr(8'h12, v);
    chk("ind code", {5'h0, ctrl_o.indicator_code}, {5'h0, v[2:0]});
    // master ack re-reads the same register
    exp_q.push_back({5'h1F, v[2:0]});
    exp_q.push_back({5'h1F, v[2:0]});
    m.start();
    m.send_byte(8'hA6, a1);
    m.send_byte(8'h12, a2);
    m.start();
    m.send_byte(8'hA7, a1);
    chk("reread ack", {7'h0, a1}, 8'h01);
    m.recv_byte(1'b0, rb);
    m.recv_byte(1'b1, rb);
    m.stop();
    for (int k = 0; k < 3; k++) begin
      wr(8'h10, 8'(k));
      chk("mode", {6'h0, ctrl_o.mode}, 8'(k));
    end
    // level strobe: ends when the trigger drops, long before timeout
    wr(8'hC0, 8'hEF);
    wr(8'h10, 8'h03);
    chk("flash mode", {6'h0, ctrl_o.mode}, 8'h03);
    trigger_i = 1'b1;
    wait_flash(1'b1, 10);
    repeat (20) @(negedge core_clk);
    trigger_i = 1'b0;
    wait_flash(1'b0, 10);
    chk("mode cleared", {6'h0, ctrl_o.mode}, 8'h00);
    // edge strobe with code 1: two steps of 16 cycles
    wr(8'hC0, 8'h21);
    wr(8'h10, 8'h07);
    trigger_i = 1'b1;
    repeat (3) @(negedge core_clk);
    trigger_i = 1'b0;
    wait_flash(1'b1, 10);
    wait_flash(1'b0, 80);
    chk("pulse length", {7'h0, n >= 30 && n <= 34}, 8'h01);
    chk("mode cleared", {6'h0, ctrl_o.mode}, 8'h00);
    rd(8'hD0, 8'h01);
    rd(8'hD0, 8'h00);
    // pin one output high, pin two input
    wr(8'h20, 8'h0F);
    chk("pin one oe", {7'h0, aux_pin_one_oe}, 8'h01);
    chk("pin one o", {7'h0, aux_pin_one_o}, 8'h01);
    ext2 = 1'b1;
    rd(8'h20, 8'hAF);
    wr(8'h20, 8'h58);
    chk("pin two oe", {7'h0, aux_pin_two_oe}, 8'h00);
    fault_i.led_thermal_fault = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("pin two int", {7'h0, aux2_w}, 8'h00);
    fault_i = 4'b1101;
    repeat (8) @(negedge core_clk);
    fault_i = '0;
    rd(8'hD0, 8'hA6);
    chk("pin two idle", {7'h0, aux2_w}, 8'h01);
    rd(8'hD0, 8'h00);
    rd(8'h20, 8'hD8);
    // pin two as plain output high, pin one as event input
    wr(8'h20, 8'h38);
    chk("pin two o", {6'h0, aux_pin_two_oe, aux_pin_two_o}, 8'h03);
    ext1 = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(8'hD0, 8'h08);
    chk("queue empty", 8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule // tb
